/* vsdtm_top.sv */
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "vsdtm_defs.svh"

// Operation
// [R01] kernel, supervisor, user widths each chosen by own status bit
// [R02] user width bit clear: 32-bit user addresses, 2 GB space
// [R03] user width bit set: 64-bit user addresses, 1 TB space
// [R04] lookup address is extended with the 8-bit space identifier
// [R05] physical addresses are 36 bits, 64 GB space
// [R06] hit needs equal page number and global bit or equal identifier
// [R07] mapped reference with no hit flags a tlb miss
// [R08] physical frame joined with untranslated in-page offset on hit
// [R09] 32-bit: 4 KB uses 12/20 split, 16 MB uses 24/8 split
// [R10] 64-bit: 4 KB uses 28-bit page number, 16 MB uses 16-bit
// [R11] user mode: privilege 10 with both level flags clear
// [R12] supervisor mode: privilege 01 with both level flags clear
// [R13] 32-bit user mode with address bit 31 set is address error
// [R14] 64-bit user mode with bits 63:40 nonzero is address error
// [R15] user segment misses: 32-bit normal vector, 64-bit extended
// [R16] supervisor misses use vector chosen by supervisor width bit
// [R17] user segment mapped alike from all modes, cache from entry; unmapped in kernel with the error level flag set
// [R18] supervisor space reachable only from supervisor and kernel
// [R19] supervisor view, top 00, user bit clear: 2 GB user segment
// [R20] supervisor view, top 00, user bit set: 1 TB user segment
// [R21] supervisor bit set, top 01: 1 TB supervisor segment
// [R22] 48 entries compared in parallel, each an even/odd pair
// [R23] decode, error and hit/miss given together one cycle later
module vsdtm_top #(
    parameter int TLB_ENTRIES = `VSDTM_TLB_ENTRIES
) (
    input wire logic clock, // core clock
    input wire logic resetn, // async reset, active low
    input wire vsdtm_pkg::vsdtm_req_type req, // pipeline lookup
    output vsdtm_pkg::vsdtm_rsp_type rsp, // lookup answer
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [`VSDTM_AXI_AW-1:0] s_axi_awaddr, // write addr
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    output logic [1:0] s_axi_bresp, // write response
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    input wire logic [`VSDTM_AXI_AW-1:0] s_axi_araddr, // read addr
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp // read response
);
    import vsdtm_pkg::*;

    // ======================================================
    // state
    logic [`VSDTM_ST_W-1:0] status_r;
    logic [`VSDTM_SPACE_IDENTIFIER_W-1:0] entry_high_r;
    logic [31:0] stg_vpn_r, stg_attr_r, stg_pfn0_r, stg_pfn1_r;
    logic [`VSDTM_CNT_W-1:0] miss_count_r;
    logic [6:0] last_result_r;
    vsdtm_rsp_type rsp_r, rsp_nxt;
    vsdtm_entry_type tlb_mem [TLB_ENTRIES];
    logic [TLB_ENTRIES-1:0] entry_valid_r;
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r, wdata_r;
    logic [3:0] wstrb_r;
    logic [`VSDTM_AXI_AW-1:0] awaddr_r;

    // ======================================================
    // mode and width decode
    wire logic kx = status_r[`VSDTM_ST_KX];
    wire logic sx = status_r[`VSDTM_ST_SX];
    wire logic ux = status_r[`VSDTM_ST_UX];
    wire logic exception_level_flag = status_r[`VSDTM_ST_EXL];
    wire logic error_level_flag = status_r[`VSDTM_ST_ERL];
    wire logic [1:0] priv_field =
        status_r[`VSDTM_ST_PRIV_MSB:`VSDTM_ST_PRIV_LSB];
    // [R11] user mode
    wire logic user_mode =
        (priv_field == `VSDTM_PRIV_USER) && !exception_level_flag && !error_level_flag;
    // [R12] supervisor mode
    wire logic super_mode =
        (priv_field == `VSDTM_PRIV_SUPER) && !exception_level_flag && !error_level_flag;
    wire vsdtm_mode_type cur_mode = user_mode ? VSDTM_USER :
        (super_mode ? VSDTM_SUPER : VSDTM_KERNEL);
    // [R01] width bit of the current view
    wire logic wide = (cur_mode == VSDTM_USER) ? ux :
        ((cur_mode == VSDTM_SUPER) ? sx : kx);

    // [R09] narrow view: only low word counts, sign extended
    wire logic [63:0] eff = wide ? req.vaddr :
        {{32{req.vaddr[31]}}, req.vaddr[31:0]};

    // ======================================================
    // segment decode
    // [R02] [R19] 2 GB user segment
    wire logic useg_narrow = (eff[63:`VSDTM_USEG32_TOP] == '0);
    // [R03] [R20] 1 TB user segment
    wire logic useg_wide = (eff[63:`VSDTM_USER_TOP] == '0);
    wire logic user_seg = ux ? useg_wide : useg_narrow;
    // 512 MB supervisor window, same pattern in both widths
    wire logic sseg_low = (&eff[63:32]) &&
        (eff[31:`VSDTM_SSEG_LSB] == `VSDTM_SSEG_PAT);
    // [R21] 1 TB wide supervisor segment
    wire logic xsseg = wide && sx &&
        (eff[63:62] == `VSDTM_XSSEG_PAT) &&
        (eff[61:`VSDTM_USER_TOP] == '0);
    // [R18] supervisor space closed to user mode
    wire logic super_seg = (sseg_low || xsseg) && !user_mode;
    // [R13] [R14] illegal user or supervisor view addresses
    wire logic addr_err = (cur_mode != VSDTM_KERNEL) &&
        !(user_seg || super_seg);
    // kernel segments and error-level user region bypass the tlb
    wire logic unmapped = (cur_mode == VSDTM_KERNEL) &&
        (!(user_seg || super_seg) || (error_level_flag && user_seg));
    // [R17] user segment mapped in every mode except kernel with the error level flag set
    wire logic mapped = req.valid && !addr_err && !unmapped;
    // [R15] [R16] refill vector by segment width bit
    wire logic xrefill = user_seg ? ux : sx;

    // ======================================================
    // fully associative match
    logic [TLB_ENTRIES-1:0] hit_vec;
    // [R22] every entry compared at once
    genvar gi;
    generate
        for (gi = 0; gi < TLB_ENTRIES; gi++) begin : g_match
            wire vsdtm_entry_type ent = tlb_mem[gi];
            // [R10] small pages compare the low page bits too
            wire logic vpn_eq = (ent.region == eff[63:62]) &&
                (ent.vpn2[26:12] == eff[39:25]) &&
                (ent.big_page || (ent.vpn2[11:0] == eff[24:13]));
            // [R04] [R06] identifier or global bit
            wire logic id_eq = ent.global_map ||
                (ent.space_identifier == entry_high_r);
            assign hit_vec[gi] = entry_valid_r[gi] && vpn_eq && id_eq;
        end
    endgenerate

    // several hits are software's fault; the highest index wins
    logic [`VSDTM_PFN_W-1:0] sel_pfn;
    logic [`VSDTM_CACHE_W-1:0] sel_cache;
    logic sel_big;
    always_comb begin
        sel_pfn = '0;
        sel_cache = '0;
        sel_big = 1'b0;
        for (int i = 0; i < TLB_ENTRIES; i++) begin
            if (hit_vec[i]) begin
                sel_big = tlb_mem[i].big_page;
                if (tlb_mem[i].big_page ? eff[`VSDTM_OFF_BIG] :
                    eff[`VSDTM_OFF_SMALL]) begin
                    sel_pfn = tlb_mem[i].pfn1;
                    sel_cache = tlb_mem[i].cache1;
                end else begin
                    sel_pfn = tlb_mem[i].pfn0;
                    sel_cache = tlb_mem[i].cache0;
                end
            end
        end
    end

    wire logic any_hit = mapped && (|hit_vec);
    // [R05] [R08] frame plus untranslated offset
    wire logic [`VSDTM_PA_W-1:0] pa_small =
        {sel_pfn, eff[`VSDTM_OFF_SMALL-1:0]};
    wire logic [`VSDTM_PA_W-1:0] pa_big =
        {sel_pfn[`VSDTM_PFN_W-1:`VSDTM_OFF_BIG-`VSDTM_OFF_SMALL],
         eff[`VSDTM_OFF_BIG-1:0]};

    always_comb begin
        rsp_nxt = '0;
        rsp_nxt.valid = req.valid;
        rsp_nxt.addr_err = req.valid && addr_err;
        rsp_nxt.unmapped = req.valid && unmapped;
        rsp_nxt.super_seg = req.valid && super_seg;
        rsp_nxt.hit = any_hit;
        // [R07] miss on a mapped reference
        rsp_nxt.tlb_miss = mapped && !(|hit_vec);
        rsp_nxt.xrefill = mapped && !(|hit_vec) && xrefill;
        rsp_nxt.cache = any_hit ? sel_cache : '0;
        rsp_nxt.paddr = any_hit ? (sel_big ? pa_big : pa_small) : '0;
    end

    // [R23] all flags registered together
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            miss_count_r <= '0;
            last_result_r <= '0;
        end else if (rsp_nxt.valid) begin
            last_result_r <= {rsp_nxt.hit, rsp_nxt.tlb_miss,
                rsp_nxt.addr_err, rsp_nxt.xrefill, rsp_nxt.unmapped,
                rsp_nxt.super_seg, rsp_nxt.valid};
            if (rsp_nxt.tlb_miss) begin
                miss_count_r <= miss_count_r + 1'b1;
            end
        end
    end

    // ======================================================
    // axi4-lite write channel
    wire logic aw_fire = s_axi_awvalid && awready_r;
    wire logic w_fire = s_axi_wvalid && wready_r;
    wire logic wr_do = !awready_r && !wready_r && !bvalid_r;
    wire logic b_fire = bvalid_r && s_axi_bready;
    wire logic wr_known = (awaddr_r == `VSDTM_REG_STATUS) ||
        (awaddr_r == `VSDTM_REG_ENTRY_HIGH) ||
        (awaddr_r == `VSDTM_REG_STG_VPN) ||
        (awaddr_r == `VSDTM_REG_STG_ATTR) ||
        (awaddr_r == `VSDTM_REG_STG_PFN0) ||
        (awaddr_r == `VSDTM_REG_STG_PFN1) ||
        (awaddr_r == `VSDTM_REG_TLB_WRITE) ||
        (awaddr_r == `VSDTM_REG_LAST_RESULT) ||
        (awaddr_r == `VSDTM_REG_MISS_COUNT);
    wire logic [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
        {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    function automatic logic [31:0] merge(input logic [31:0] old);
        merge = (old & ~wmask) | (wdata_r & wmask);
    endfunction
    wire logic [31:0] status_m = merge({25'h0000000, status_r});
    wire logic [31:0] ehi_m = merge({24'h000000, entry_high_r});
    wire logic [`VSDTM_IDX_W-1:0] wr_idx = wdata_r[`VSDTM_IDX_W-1:0];
    // a commit needs the low byte and an index inside the array
    wire logic tlb_commit = wr_do && wstrb_r[0] &&
        (awaddr_r == `VSDTM_REG_TLB_WRITE) &&
        (32'(wr_idx) < TLB_ENTRIES);
    wire vsdtm_entry_type stg_entry = '{
        global_map: stg_attr_r[`VSDTM_AT_GLOBAL],
        big_page: stg_attr_r[`VSDTM_AT_BIG],
        region: stg_vpn_r[28:27],
        vpn2: stg_vpn_r[26:0],
        space_identifier: stg_attr_r[`VSDTM_SPACE_IDENTIFIER_W-1:0],
        pfn0: stg_pfn0_r[23:0],
        cache0: stg_pfn0_r[26:24],
        pfn1: stg_pfn1_r[23:0],
        cache1: stg_pfn1_r[26:24]};

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= `VSDTM_RESP_OKAY;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            if (aw_fire) begin
                awready_r <= 1'b0;
                awaddr_r <= s_axi_awaddr;
            end
            if (w_fire) begin
                wready_r <= 1'b0;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_do) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_known ? `VSDTM_RESP_OKAY :
                    `VSDTM_RESP_DECERR;
            end
            if (b_fire) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            status_r <= `VSDTM_ST_RST;
            entry_high_r <= '0;
            stg_vpn_r <= '0;
            stg_attr_r <= '0;
            stg_pfn0_r <= '0;
            stg_pfn1_r <= '0;
        end else if (wr_do) begin
            if (awaddr_r == `VSDTM_REG_STATUS) begin
                status_r <= status_m[`VSDTM_ST_W-1:0];
            end
            if (awaddr_r == `VSDTM_REG_ENTRY_HIGH) begin
                entry_high_r <= ehi_m[`VSDTM_SPACE_IDENTIFIER_W-1:0];
            end
            if (awaddr_r == `VSDTM_REG_STG_VPN) begin
                stg_vpn_r <= merge(stg_vpn_r) & 32'h1FFFFFFF;
            end
            if (awaddr_r == `VSDTM_REG_STG_ATTR) begin
                stg_attr_r <= merge(stg_attr_r) & 32'h000007FF;
            end
            if (awaddr_r == `VSDTM_REG_STG_PFN0) begin
                stg_pfn0_r <= merge(stg_pfn0_r) & 32'h07FFFFFF;
            end
            if (awaddr_r == `VSDTM_REG_STG_PFN1) begin
                stg_pfn1_r <= merge(stg_pfn1_r) & 32'h07FFFFFF;
            end
        end
    end

    // entry storage has no reset; only the valid bits do
    always_ff @(posedge clock) begin
        if (tlb_commit) begin
            tlb_mem[wr_idx] <= stg_entry;
        end
    end

    generate
        for (gi = 0; gi < TLB_ENTRIES; gi++) begin : g_valid
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    entry_valid_r[gi] <= 1'b0;
                end else if (tlb_commit && (32'(wr_idx) == gi)) begin
                    entry_valid_r[gi] <= stg_attr_r[`VSDTM_AT_VALID];
                end
            end
        end
    endgenerate

    // ======================================================
    // axi4-lite read channel
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            `VSDTM_REG_STATUS: rd_val = {25'h0000000, status_r};
            `VSDTM_REG_ENTRY_HIGH: rd_val = {24'h000000, entry_high_r};
            `VSDTM_REG_STG_VPN: rd_val = stg_vpn_r;
            `VSDTM_REG_STG_ATTR: rd_val = stg_attr_r;
            `VSDTM_REG_STG_PFN0: rd_val = stg_pfn0_r;
            `VSDTM_REG_STG_PFN1: rd_val = stg_pfn1_r;
            `VSDTM_REG_TLB_WRITE: rd_val = 32'h00000000;
            `VSDTM_REG_LAST_RESULT: rd_val = {25'h0000000, last_result_r};
            `VSDTM_REG_MISS_COUNT: rd_val = miss_count_r;
            default: begin
                rd_val = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= `VSDTM_RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_val;
            rresp_r <= rd_ok ? `VSDTM_RESP_OKAY : `VSDTM_RESP_DECERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    assign rsp = rsp_r;
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

endmodule // vsdtm_top

/* vsdtm_defs.svh */
`ifndef VSDTM_DEFS_SVH
`define VSDTM_DEFS_SVH

// ==========================================================
// sizes
`define VSDTM_TLB_ENTRIES 48
`define VSDTM_SPACE_IDENTIFIER_W 8
`define VSDTM_PA_W 36
`define VSDTM_PFN_W 24
`define VSDTM_VPN2_W 27
`define VSDTM_CACHE_W 3
`define VSDTM_IDX_W 6
`define VSDTM_AXI_AW 8
`define VSDTM_CNT_W 32

// ==========================================================
// virtual address layout
`define VSDTM_OFF_SMALL 12
`define VSDTM_OFF_BIG 24
`define VSDTM_USER_TOP 40
`define VSDTM_USEG32_TOP 31
`define VSDTM_SSEG_LSB 29
`define VSDTM_SSEG_PAT 3'h6
`define VSDTM_XSSEG_PAT 2'h1

// ==========================================================
// register offsets (byte addresses)
`define VSDTM_REG_STATUS 8'h00
`define VSDTM_REG_ENTRY_HIGH 8'h04
`define VSDTM_REG_STG_VPN 8'h08
`define VSDTM_REG_STG_ATTR 8'h0C
`define VSDTM_REG_STG_PFN0 8'h10
`define VSDTM_REG_STG_PFN1 8'h14
`define VSDTM_REG_TLB_WRITE 8'h18
`define VSDTM_REG_LAST_RESULT 8'h1C
`define VSDTM_REG_MISS_COUNT 8'h20

// ==========================================================
// status register fields
`define VSDTM_ST_KX 0
`define VSDTM_ST_SX 1
`define VSDTM_ST_UX 2
`define VSDTM_ST_PRIV_LSB 3
`define VSDTM_ST_PRIV_MSB 4
`define VSDTM_ST_EXL 5
`define VSDTM_ST_ERL 6
`define VSDTM_ST_W 7
`define VSDTM_ST_RST 7'h00

// staging attribute fields
`define VSDTM_AT_GLOBAL 8
`define VSDTM_AT_BIG 9
`define VSDTM_AT_VALID 10
`define VSDTM_AT_W 11

// privilege codes
`define VSDTM_PRIV_USER 2'h2
`define VSDTM_PRIV_SUPER 2'h1

// axi responses
`define VSDTM_RESP_OKAY 2'h0
`define VSDTM_RESP_DECERR 2'h3

`endif

/* vsdtm_pkg.sv */
package vsdtm_pkg;
`include "vsdtm_defs.svh"

    // ======================================================
    // pipeline carriers
    typedef struct packed {
        logic valid;
        logic [63:0] vaddr;
    } vsdtm_req_type;

    typedef struct packed {
        logic valid;
        logic hit;
        logic tlb_miss;
        logic addr_err;
        logic xrefill;
        logic unmapped;
        logic super_seg;
        logic [`VSDTM_CACHE_W-1:0] cache;
        logic [`VSDTM_PA_W-1:0] paddr;
    } vsdtm_rsp_type;

    // ======================================================
    // one tlb entry: an even/odd page pair
    typedef struct packed {
        logic global_map;
        logic big_page;
        logic [1:0] region;
        logic [`VSDTM_VPN2_W-1:0] vpn2;
        logic [`VSDTM_SPACE_IDENTIFIER_W-1:0] space_identifier;
        logic [`VSDTM_PFN_W-1:0] pfn0;
        logic [`VSDTM_CACHE_W-1:0] cache0;
        logic [`VSDTM_PFN_W-1:0] pfn1;
        logic [`VSDTM_CACHE_W-1:0] cache1;
    } vsdtm_entry_type;

    typedef enum logic [1:0] {
        VSDTM_KERNEL = 2'b00,
        VSDTM_SUPER = 2'b01,
        VSDTM_USER = 2'b10
    } vsdtm_mode_type;

endpackage

/* vsdtm_chk.sv */
`timescale 1ns/1ps
// ==========================================================
// lookup checker, watches the pipeline side of the top
module vsdtm_chk
    import vsdtm_pkg::*;
#(
    parameter int TLB_ENTRIES = 48
) (
    input wire logic clock, // core clock
    input wire logic resetn, // async reset, active low
    input wire vsdtm_pkg::vsdtm_req_type req, // pipeline lookup
    input wire vsdtm_pkg::vsdtm_rsp_type rsp // lookup answer
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // a reference and its answer one edge later
    sequence s_take;
        req.valid ##1 rsp.valid;
    endsequence

    a_answer_next: assert property (req.valid |=> rsp.valid)
        else $error("lookup answer missing one cycle after request");
    a_idle_quiet: assert property (!req.valid |=>
        !rsp.valid && !rsp.hit && !rsp.tlb_miss && !rsp.addr_err)
        else $error("answer flags raised with no request");
    a_one_outcome: assert property (s_take |->
        $onehot({rsp.hit, rsp.tlb_miss, rsp.addr_err, rsp.unmapped}))
        else $error("lookup outcome not exactly one of four");
    a_offset_pass: assert property (s_take ##0 rsp.hit |->
        rsp.paddr[11:0] == $past(req.vaddr[11:0]))
        else $error("in-page offset altered on hit");
    a_useg_legal: assert property (
        req.valid && req.vaddr[63:31] == 33'h0 |=> !rsp.addr_err)
        else $error("address error on low user segment address");
    a_xrefill_miss: assert property (rsp.xrefill |-> rsp.tlb_miss)
        else $error("extended vector flagged without a miss");
    a_super_legal: assert property (rsp.super_seg |-> !rsp.addr_err)
        else $error("supervisor segment reference flagged as error");
    // kernel direct segments never reach the translation array
    a_direct_unmapped: assert property (
        req.valid && req.vaddr[63:30] == 34'h3FFFFFFFE
        |=> !rsp.hit && !rsp.tlb_miss)
        else $error("direct kernel segment looked up in the array");
endmodule // vsdtm_chk

bind vsdtm_top vsdtm_chk #(.TLB_ENTRIES(TLB_ENTRIES)) u_chk (
    .clock(clock), .resetn(resetn), .req(req), .rsp(rsp));

/* vsdtm_pipe_model.sv */
`timescale 1ns/1ps
// ==========================================================
// pipeline stand-in: one reference per call
module vsdtm_pipe_model
    import vsdtm_pkg::*;
(
    input wire logic clock, // core clock
    input wire logic resetn, // core reset, active low
    output vsdtm_pkg::vsdtm_req_type req, // lookup request
    input wire vsdtm_pkg::vsdtm_rsp_type rsp // lookup answer
);
    initial req = '0;

    // released address shows its inverse so a stale value never matches
    task automatic issue(input logic [63:0] va, output vsdtm_rsp_type r);
        req <= '{valid: 1'b1, vaddr: va};
        @(posedge clock);
        req <= '{valid: 1'b0, vaddr: ~va};
        @(negedge clock);
        r = rsp;
        @(posedge clock);
    endtask
endmodule // vsdtm_pipe_model

/* testbench.sv */
`timescale 1ns/1ps
`include "vsdtm_defs.svh"
// ==========================================================
// register and lookup bench
module testbench;
    import vsdtm_pkg::*;
    logic clock, resetn;
    vsdtm_req_type req;
    vsdtm_rsp_type rsp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int miscompares, tests_run;
    localparam logic [5:0] HIT = 6'h20, MISS = 6'h10, MISSX = 6'h14;
    localparam logic [5:0] ERR = 6'h08, UNM = 6'h02;
    localparam logic [5:0] SMISS = 6'h11, SMISSX = 6'h15;

    vsdtm_top uut (
        .clock(clock), .resetn(resetn), .req(req), .rsp(rsp),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp));
    vsdtm_pipe_model pipe (.clock(clock), .resetn(resetn), .req(req),
        .rsp(rsp));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ======================================================
    // verdict and comparisons
    task automatic complete_run();
        if (miscompares == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_look(input vsdtm_rsp_type g, input logic [5:0] f,
            input logic [38:0] pc);
        logic [45:0] gv;
        gv = {g.valid, g.hit, g.tlb_miss, g.addr_err, g.xrefill, g.unmapped,
            g.super_seg, g.cache, g.paddr};
        tests_run++;
        if (gv !== {1'b1, f, pc}) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, gv,
                {1'b1, f, pc});
        end
    endtask

    // ======================================================
    // bus cycles; readiness is sampled at the falling edge, where it
    // already holds the value the next rising edge will see
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        logic ta, tw, tb;
        logic [1:0] rs;
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        tb = 1'b0;
        for (n = 0; n < 60 && !tb; n++) begin
            @(negedge clock);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid === 1'b1;
            rs = s_axi_bresp;
            @(posedge clock);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        if (!tb) begin
            miscompares++;
            complete_run();
        end else begin
            chk_word({30'h0, rs}, {30'h0, {2{a > 8'h20}}});
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] ed,
            input logic [1:0] er);
        logic ta, tr;
        logic [31:0] dat;
        logic [1:0] rs;
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        tr = 1'b0;
        for (n = 0; n < 60 && !tr; n++) begin
            @(negedge clock);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid === 1'b1;
            dat = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clock);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        if (!tr) begin
            miscompares++;
            complete_run();
        end else begin
            chk_word(dat, ed);
            chk_word({30'h0, rs}, {30'h0, er});
        end
    endtask

    task automatic set_status(input logic [31:0] d);
        wr(`VSDTM_REG_STATUS, d);
    endtask

    // even page frame 0x01234A cache 3, odd page frame 0xABCDEF cache 5
    task automatic put_entry(input logic [5:0] idx, input logic [28:0] virtual_page_number,
            input logic [10:0] attr);
        wr(`VSDTM_REG_STG_VPN, {3'h0, virtual_page_number});
        wr(`VSDTM_REG_STG_ATTR, {21'h0, attr});
        wr(`VSDTM_REG_STG_PFN0, 32'h0301234A);
        wr(`VSDTM_REG_STG_PFN1, 32'h05ABCDEF);
        wr(`VSDTM_REG_TLB_WRITE, {26'h0, idx});
    endtask

    task automatic look(input logic [63:0] va, input logic [5:0] f,
            input logic [38:0] pc);
        pipe.issue(va, r);
        chk_look(r, f, pc);
    endtask

    // ======================================================
    // main sequence
    initial begin
        resetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        miscompares = 0;
        tests_run = 0;
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        rchk(`VSDTM_REG_STATUS, 32'h0, 2'h0);
        rchk(8'h40, 32'h0, 2'h3);
        wr(8'h40, 32'h0);
        set_status(32'h07);
        rchk(`VSDTM_REG_STATUS, 32'h07, 2'h0);
        set_status(32'h00);
        wr(`VSDTM_REG_ENTRY_HIGH, 32'h5A);
        put_entry(6'h05, 29'h91A2, 11'h45A);
        look(64'h12345678, HIT, {3'h5, 24'hABCDEF, 12'h678});
        look(64'h12344678, HIT, {3'h3, 24'h01234A, 12'h678});
        wr(`VSDTM_REG_ENTRY_HIGH, 32'h5B);
        look(64'h12345678, MISS, 39'h0);
        put_entry(6'h05, 29'h91A2, 11'h55A);
        look(64'h12345678, HIT, {3'h5, 24'hABCDEF, 12'h678});
        put_entry(6'h2F, 29'h2D000, 11'h700);
        look(64'h5B123456, HIT, {3'h5, 12'hABC, 24'h123456});
        put_entry(6'h06, 29'h55E6F01, 11'h500);
        set_status(32'h14);
        look(64'h000000ABCDE03ABC, HIT, {3'h5, 24'hABCDEF, 12'hABC});
        look(64'h000000FF00000000, MISSX, 39'h0);
        look(64'h0000010000000000, ERR, 39'h0);
        set_status(32'h10);
        look(64'hFFFFFFFF80000000, ERR, 39'h0);
        look(64'h12345678, HIT, {3'h5, 24'hABCDEF, 12'h678});
        look(64'hFFFFFFFFC0000000, ERR, 39'h0);
        set_status(32'h30);
        look(64'hFFFFFFFF80000000, UNM, 39'h0);
        set_status(32'h08);
        look(64'hFFFFFFFFC0000000, SMISS, 39'h0);
        look(64'h12345678, HIT, {3'h5, 24'hABCDEF, 12'h678});
        set_status(32'h0A);
        look(64'h7FFFF000, MISS, 39'h0);
        set_status(32'h0E);
        look(64'h4000000000000000, SMISSX, 39'h0);
        look(64'h000000ABCDE03ABC, HIT, {3'h5, 24'hABCDEF, 12'hABC});
        set_status(32'h03);
        look(64'h4000000000000000, SMISSX, 39'h0);
        complete_run();
    end
endmodule // testbench
